// ### src/dcq_channel_ctrl.sv
// Channel controller: event capture, arbitration, queuing, submission and set update.
module dcq_channel_ctrl (
    input  wire logic                                   clk_sys_i,
    input  wire logic                                   rst_n_i,
    input  wire logic [dcq_pkg::N_DMA-1:0]              dma_evt_i,
    input  wire logic [dcq_pkg::N_DMA-1:0]              sw_evt_set_i,
    input  wire logic                                   ctx_wr_i,
    input  wire logic [dcq_pkg::SET_W-1:0]              ctx_wr_set_i,
    input  wire logic [dcq_pkg::WORD_W-1:0]             ctx_wr_word_i,
    input  wire logic [31:0]                            ctx_wr_data_i,
    input  wire logic [dcq_pkg::N_QCH*dcq_pkg::SET_W-1:0] qch_map_i,
    input  wire logic [dcq_pkg::N_DMA-1:0]              dma_que_sel_i,
    input  wire logic [dcq_pkg::N_QCH-1:0]              qch_que_sel_i,
    input  wire logic                                   err_clr_i,
    input  wire logic [dcq_pkg::N_QUE-1:0]              te_ready_i,
    output logic      [dcq_pkg::N_QUE-1:0]              te_req_valid_o,
    output logic      [31:0]                            te_req_opt_o,
    output logic      [31:0]                            te_req_src_o,
    output logic      [31:0]                            te_req_dst_o,
    output logic      [31:0]                            te_req_cnt_o,
    output logic      [31:0]                            te_req_bidx_o,
    output logic      [31:0]                            te_req_cidx_o,
    output logic      [dcq_pkg::HALF_W-1:0]             te_req_ccnt_o,
    output logic                                        done_irq_o,
    output logic      [dcq_pkg::CH_W-1:0]               done_code_o,
    output logic                                        err_irq_o,
    output logic      [dcq_pkg::N_DMA-1:0]              dma_missed_o,
    output logic      [dcq_pkg::N_QCH-1:0]              qch_missed_o,
    output logic                                        null_err_o,
    output logic      [dcq_pkg::N_QUE-1:0]              que_ovf_o,
    output logic      [dcq_pkg::N_QUE*dcq_pkg::CNT_W-1:0] que_occ_o,
    output logic      [dcq_pkg::N_QUE*dcq_pkg::CNT_W-1:0] que_wmark_o
);
    import dcq_pkg::*;

    // Lowest set bit wins; the loop runs downward so the last hit is the smallest index.
    function automatic logic [CH_W-1:0] low_idx(input logic [N_DMA-1:0] v);
        low_idx = '0;
        for (int i = N_DMA - 1; i >= 0; i--) begin
            if (v[i]) begin
                low_idx = CH_W'(i);
            end
        end
    endfunction

    // Indexes are signed sixteen-bit steps, widened here to a full address step.
    function automatic logic [31:0] sext(input logic [HALF_W-1:0] v);
        sext = {{HALF_W{v[HALF_W-1]}}, v};
    endfunction

    logic [31:0]       ctx_ram [N_SET*N_WORD];
    dcq_state_t        st_r;
    dcq_entry_t        cur_r;
    logic              cur_q_r;
    logic [N_DMA-1:0]  dma_pend_r;
    logic [N_QCH-1:0]  qch_pend_r;
    logic [N_DMA-1:0]  dma_missed_r;
    logic [N_QCH-1:0]  qch_missed_r;
    logic              null_err_r;
    logic [N_QUE-1:0]  ovf_r;
    logic              chain_vld_r;
    logic [CH_W-1:0]   chain_ch_r;
    logic [WORD_W-1:0] link_cnt_r;
    logic [SET_W-1:0]  link_set_r;
    logic [N_QUE-1:0]  te_valid_r;
    logic [31:0]       w [N_WORD];
    logic [N_QCH-1:0]  qtrig;
    logic [N_QUE-1:0]  q_full;
    logic [N_QUE-1:0]  q_empty;
    logic [N_QUE-1:0]  pop;
    logic [ENT_W-1:0]  q_head [N_QUE];

    // Quick-channel trigger decode: a write to the trigger word of a mapped set.
    for (genvar k = 0; k < N_QCH; k++) begin : g_qtrig
        assign qtrig[k] = ctx_wr_i && (ctx_wr_word_i == QTRIG_WORD) &&
                          (ctx_wr_set_i == qch_map_i[k*SET_W +: SET_W]);
    end

    // Event capture; an event that lands in the cycle its bit is taken stays pending.
    logic [N_DMA-1:0] chain_vec;
    logic [N_DMA-1:0] dma_new;
    logic [N_DMA-1:0] dma_take;
    logic [N_DMA-1:0] dma_miss;
    logic [N_QCH-1:0] qch_take;
    logic [N_QCH-1:0] qch_miss;
    assign chain_vec = chain_vld_r ? (N_DMA'(1) << chain_ch_r) : '0;
    assign dma_new   = dma_evt_i | sw_evt_set_i | chain_vec;
    assign dma_miss  = dma_new & dma_pend_r & ~dma_take;
    assign qch_miss  = qtrig & qch_pend_r & ~qch_take;

    // Arbitration between the two encoders and choice of the queue.
    logic             dma_any;
    logic             qch_any;
    logic [CH_W-1:0]  dma_idx;
    logic [QCH_W-1:0] qch_idx;
    logic             win_que;
    logic             push_ok;
    dcq_entry_t       win_ent;
    assign dma_any = |dma_pend_r;
    assign qch_any = |qch_pend_r;
    assign dma_idx = low_idx(dma_pend_r);
    assign qch_idx = QCH_W'(low_idx({{(N_DMA-N_QCH){1'b0}}, qch_pend_r}));
    assign win_ent.quick = !dma_any;
    assign win_ent.chan  = dma_any ? dma_idx : CH_W'(qch_idx);
    assign win_ent.set   = dma_any ? SET_W'(dma_idx) : qch_map_i[qch_idx*SET_W +: SET_W];
    assign win_que = dma_any ? dma_que_sel_i[dma_idx] : qch_que_sel_i[qch_idx];
    // A full target queue holds the winner pending, which also stalls every other pending channel.
    assign push_ok  = (dma_any || qch_any) && !q_full[win_que];
    assign dma_take = (push_ok && dma_any) ? (N_DMA'(1) << dma_idx) : '0;
    assign qch_take = (push_ok && !dma_any) ? (N_QCH'(1) << qch_idx) : '0;

    // Two event queues, one per transfer engine.
    dcq_eq_if #(.W(ENT_W), .CW(CNT_W)) eq [N_QUE] ();
    for (genvar g = 0; g < N_QUE; g++) begin : g_que
        dcq_event_queue #(.W(ENT_W), .DEPTH(Q_DEPTH)) u_que (
            .clk_sys_i (clk_sys_i),
            .rst_n_i   (rst_n_i),
            .q         (eq[g])
        );
        assign eq[g].push  = push_ok && (win_que == 1'(g));
        assign eq[g].wdata = win_ent;
        assign eq[g].pop   = pop[g];
        assign q_full[g]   = eq[g].full;
        assign q_empty[g]  = eq[g].empty;
        assign q_head[g]   = eq[g].rdata;
        assign que_occ_o[g*CNT_W +: CNT_W]   = eq[g].count;
        assign que_wmark_o[g*CNT_W +: CNT_W] = eq[g].wmark;
    end

    // Extraction: first queue wins when both engines are ready.
    assign pop[0] = (st_r == S_IDLE) && !q_empty[0] && te_ready_i[0];
    assign pop[1] = (st_r == S_IDLE) && !q_empty[1] && te_ready_i[1] && !pop[0];

    // Read port on the current set and the field decode of its words.
    for (genvar i = 0; i < N_WORD; i++) begin : g_rd
        assign w[i] = ctx_ram[{cur_r.set, WORD_W'(i)}];
    end
    logic [HALF_W-1:0] bcnt;
    logic [HALF_W-1:0] ccnt;
    logic [HALF_W-1:0] link;
    logic              is_null;
    logic              row_end;
    logic              last_trig;
    logic              submit;
    logic [31:0]       src_step;
    logic [31:0]       dst_step;
    logic [HALF_W-1:0] bcnt_nxt;
    assign bcnt      = w[W_CNT][31:HALF_W];
    assign ccnt      = w[W_CCNT][HALF_W-1:0];
    assign link      = w[W_LINK][HALF_W-1:0];
    assign is_null   = ~|{w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
    assign submit    = (st_r == S_SUBMIT) && !is_null;
    // Frame-per-request mode always steps the frame index (CIDX); array mode steps it at a frame end.
    assign row_end   = w[W_OPT][OPT_SYNCDIM] || (bcnt <= HALF_W'(1));
    assign last_trig = row_end && (ccnt <= HALF_W'(1));
    assign src_step  = row_end ? sext(w[W_CIDX][HALF_W-1:0]) : sext(w[W_BIDX][HALF_W-1:0]);
    assign dst_step  = row_end ? sext(w[W_CIDX][31:HALF_W]) : sext(w[W_BIDX][31:HALF_W]);
    assign bcnt_nxt  = w[W_OPT][OPT_SYNCDIM] ? bcnt :
                       (row_end ? w[W_LINK][31:HALF_W] : bcnt - HALF_W'(1));

    // Context memory: software writes first, the controller's update of the same word wins.
    always_ff @(posedge clk_sys_i) begin
        if (ctx_wr_i) begin
            ctx_ram[{ctx_wr_set_i, ctx_wr_word_i}] <= ctx_wr_data_i;
        end
        if (submit) begin
            ctx_ram[{cur_r.set, W_SRC}]  <= w[W_SRC] + src_step;
            ctx_ram[{cur_r.set, W_DST}]  <= w[W_DST] + dst_step;
            ctx_ram[{cur_r.set, W_CNT}]  <= {bcnt_nxt, w[W_CNT][HALF_W-1:0]};
            ctx_ram[{cur_r.set, W_CCNT}] <= {w[W_CCNT][31:HALF_W], row_end ? ccnt - HALF_W'(1) : ccnt};
        end
        if (st_r == S_LINK) begin
            ctx_ram[{cur_r.set, link_cnt_r}] <= ctx_ram[{link_set_r, link_cnt_r}];
        end
    end

    // Sequencer: pop, submit and update, then an optional eight-word reload.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_r       <= S_IDLE;
            cur_r      <= '0;
            cur_q_r    <= 1'b0;
            link_cnt_r <= '0;
            link_set_r <= '0;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (|pop) begin
                        cur_q_r <= pop[1];
                        cur_r   <= pop[1] ? q_head[1] : q_head[0];
                        st_r    <= S_SUBMIT;
                    end
                end
                S_SUBMIT: begin
                    link_cnt_r <= '0;
                    link_set_r <= link[LINK_LSB +: SET_W];
                    // Linking is always on; the null link value leaves the set as updated.
                    st_r <= (submit && last_trig && link != LINK_NULL) ? S_LINK : S_IDLE;
                end
                S_LINK: begin
                    link_cnt_r <= link_cnt_r + WORD_W'(1);
                    if (link_cnt_r == W_CCNT) begin
                        st_r <= S_IDLE;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // Request payload, completion and chaining; each option bit acts alone.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            te_valid_r    <= '0;
            te_req_opt_o  <= '0;
            te_req_src_o  <= '0;
            te_req_dst_o  <= '0;
            te_req_cnt_o  <= '0;
            te_req_bidx_o <= '0;
            te_req_cidx_o <= '0;
            te_req_ccnt_o <= '0;
            done_irq_o    <= 1'b0;
            done_code_o   <= '0;
            chain_vld_r   <= 1'b0;
            chain_ch_r    <= '0;
        end else begin
            te_valid_r  <= submit ? (N_QUE'(1) << cur_q_r) : '0;
            done_irq_o  <= submit && last_trig && w[W_OPT][OPT_TCINTEN];
            chain_vld_r <= submit && last_trig && w[W_OPT][OPT_TCCHEN];
            if (submit) begin
                te_req_opt_o  <= w[W_OPT];
                te_req_src_o  <= w[W_SRC];
                te_req_dst_o  <= w[W_DST];
                te_req_cnt_o  <= w[W_CNT];
                te_req_bidx_o <= w[W_BIDX];
                te_req_cidx_o <= w[W_CIDX];
                te_req_ccnt_o <= ccnt;
                done_code_o   <= w[W_OPT][OPT_TCC_LSB +: CH_W];
                chain_ch_r    <= w[W_OPT][OPT_TCC_LSB +: CH_W];
            end
        end
    end
    assign te_req_valid_o = te_valid_r;

    // Pending and error flags; a new set beats a clear in the same cycle.
    logic null_hit;
    logic [N_QUE-1:0] ovf_hit;
    assign null_hit = (st_r == S_SUBMIT) && is_null;
    assign ovf_hit  = ((dma_any || qch_any) && q_full[win_que]) ? (N_QUE'(1) << win_que) : '0;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            dma_pend_r   <= '0;
            qch_pend_r   <= '0;
            dma_missed_r <= '0;
            qch_missed_r <= '0;
            null_err_r   <= 1'b0;
            ovf_r        <= '0;
            err_irq_o    <= 1'b0;
        end else begin
            dma_pend_r   <= (dma_pend_r & ~dma_take) | dma_new;
            qch_pend_r   <= (qch_pend_r & ~qch_take) | qtrig;
            dma_missed_r <= (dma_missed_r & ~{N_DMA{err_clr_i}}) | dma_miss;
            qch_missed_r <= (qch_missed_r & ~{N_QCH{err_clr_i}}) | qch_miss;
            null_err_r   <= (null_err_r && !err_clr_i) || null_hit;
            ovf_r        <= (ovf_r & ~{N_QUE{err_clr_i}}) | ovf_hit;
            err_irq_o    <= (|dma_miss) || (|qch_miss) || null_hit || (|ovf_hit) ||
                            (!err_clr_i && ((|dma_missed_r) || (|qch_missed_r) || null_err_r || (|ovf_r)));
        end
    end
    assign dma_missed_o = dma_missed_r;
    assign qch_missed_o = qch_missed_r;
    assign null_err_o   = null_err_r;
    assign que_ovf_o    = ovf_r;

    // Checks on arbitration, extraction, reload and the error flags, all in the one clock domain.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    dma_first_a: assert property ((push_ok && dma_any) |-> !win_ent.quick && dma_take != '0)
        else $error("Quick event queued ahead of a pending regular event.");
    lowest_wins_a: assert property (push_ok && dma_any |-> ((dma_pend_r & dma_take) != '0) &&
        ((dma_pend_r & (dma_take - N_DMA'(1))) == '0))
        else $error("Queued regular event is not the lowest pending channel.");
    first_queue_a: assert property ((st_r == S_IDLE && !q_empty[0] && !q_empty[1] && &te_ready_i)
        |=> !cur_q_r)
        else $error("Second queue served before the first.");
    req_after_pop_a: assert property (|pop |-> ##2 (te_valid_r != '0 || null_err_r))
        else $error("Popped event produced no request or null error.");
    req_engine_a: assert property (|pop |-> ##2 (te_valid_r == '0 || te_valid_r[$past(pop[1], 2)]))
        else $error("Request sent to the wrong transfer engine.");
    missed_flag_a: assert property (dma_miss != '0 |=> (dma_missed_r & $past(dma_miss)) == $past(dma_miss))
        else $error("Missed event not recorded.");
    null_stop_a: assert property (null_hit |=> null_err_r && te_valid_r == '0 && st_r == S_IDLE)
        else $error("Null set was submitted or not flagged.");
    link_end_a: assert property ((submit && last_trig && link == LINK_NULL) |=> st_r == S_IDLE)
        else $error("Reload started on a terminated link.");
    reload_len_a: assert property ($rose(st_r == S_LINK) |-> (st_r == S_LINK)[*8] ##1 st_r == S_IDLE)
        else $error("Link reload did not copy exactly eight words.");
    quick_pend_a: assert property (qtrig != '0 |=> (qch_pend_r & $past(qtrig)) == $past(qtrig))
        else $error("Quick trigger write did not mark the channel pending.");
    ovf_flag_a: assert property (ovf_hit != '0 |=> (ovf_r & $past(ovf_hit)) == $past(ovf_hit))
        else $error("Push blocked by a full queue was not recorded.");
    done_last_a: assert property (done_irq_o |-> $past(submit && last_trig))
        else $error("Completion interrupt without a last request.");
endmodule

// ### src/dcq_pkg.sv
// Constants and types shared by the DMA channel controller and its event queues.
// Functional notes
// - Sixty-four regular channels and eight quick channels each hold a pending event.
// - Regular channels trigger from peripheral events, software set writes or chaining.
// - A write to the trigger word of a quick channel's mapped set triggers it.
// - Fixed priority encoders pick the lowest pending channel number.
// - Any pending regular event goes before any quick-channel event.
// - Winners enter one of two event queues, each drained first in first out.
// - Each event queue holds sixteen events at most.
// - When both engines are ready, the first queue is served first.
// - 128 context sets support reloading, chaining and circular buffering.
// - An event leaves its queue once its transfer engine can accept a request.
// - The extracted set is submitted, then its counts and addresses are updated.
// - Two transfer engines, one per event queue, receive requests.
// - Queue selection comes from per-channel queue-number inputs, not the set.
// - Linking is always on; link value FFFFh ends the chain with no reload.
// - Chaining and completion interrupt have separate option bits.
// - A completion interrupt and a separate error interrupt are raised.
// - Triggering an all-zero context set flags a null-set error.
// - Queue overflow and other faults are held in clearable error flags.
// - Each context set is eight 32-bit words.
// - Regular channel n always uses context set n.
// - Each quick channel maps to any of the 128 sets through its mapping input.
package dcq_pkg;
    localparam int N_DMA   = 64;
    localparam int N_QCH   = 8;
    localparam int N_SET   = 128;
    localparam int N_WORD  = 8;
    localparam int N_QUE   = 2;
    localparam int Q_DEPTH = 16;
    localparam int SET_W   = 7;
    localparam int WORD_W  = 3;
    localparam int CH_W    = 6;
    localparam int QCH_W   = 3;
    localparam int ENT_W   = 1 + CH_W + SET_W;
    localparam int CNT_W   = $clog2(Q_DEPTH) + 1;
    localparam int HALF_W  = 16;
    // Word slots inside one context set.
    localparam logic [WORD_W-1:0] W_OPT  = 3'h0;
    localparam logic [WORD_W-1:0] W_SRC  = 3'h1;
    localparam logic [WORD_W-1:0] W_CNT  = 3'h2;
    localparam logic [WORD_W-1:0] W_DST  = 3'h3;
    localparam logic [WORD_W-1:0] W_BIDX = 3'h4;
    localparam logic [WORD_W-1:0] W_LINK = 3'h5;
    localparam logic [WORD_W-1:0] W_CIDX = 3'h6;
    localparam logic [WORD_W-1:0] W_CCNT = 3'h7;
    localparam logic [WORD_W-1:0] QTRIG_WORD = 3'h7;
    localparam logic [HALF_W-1:0] LINK_NULL  = 16'hFFFF;
    localparam int LINK_LSB    = 5;
    // Bit positions inside the channel options word.
    localparam int OPT_SYNCDIM = 2;
    localparam int OPT_TCC_LSB = 12;
    localparam int OPT_TCINTEN = 20;
    localparam int OPT_TCCHEN  = 22;

    typedef enum logic [1:0] {S_IDLE, S_SUBMIT, S_LINK} dcq_state_t;

    typedef struct packed {
        logic             quick;
        logic [CH_W-1:0]  chan;
        logic [SET_W-1:0] set;
    } dcq_entry_t;
endpackage

// ### src/dcq_eq_if.sv
// Interface between the channel controller and one event queue.
interface dcq_eq_if #(parameter int W = 14, parameter int CW = 5);
    logic          push;
    logic [W-1:0]  wdata;
    logic          full;
    logic          pop;
    logic          empty;
    logic [W-1:0]  rdata;
    logic [CW-1:0] count;
    logic [CW-1:0] wmark;
    modport prod  (output push, wdata, pop, input full, empty, rdata, count, wmark);
    modport queue (input push, wdata, pop, output full, empty, rdata, count, wmark);
endinterface

// ### src/dcq_event_queue.sv
// First-in first-out event queue with occupancy and watermark.
module dcq_event_queue #(
    parameter int W     = 14,
    parameter int DEPTH = 16
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    dcq_eq_if.queue   q
);
    import dcq_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   wm_r;
    logic [AW:0]   cnt_nxt;
    logic          do_push;
    logic          do_pop;

    // A push into a full queue is dropped here, so the producer must look at full.
    assign do_push = q.push && !q.full;
    assign do_pop  = q.pop && !q.empty;
    assign cnt_nxt = cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    assign q.full  = cnt_r == (AW+1)'(DEPTH);
    assign q.empty = cnt_r == '0;
    assign q.rdata = mem[rd_r];
    assign q.count = cnt_r;
    assign q.wmark = wm_r;

    // Storage is not reset; only the pointers give it meaning.
    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem[wr_r] <= q.wdata;
        end
    end

    // Pointers, occupancy and the high watermark.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            wm_r  <= '0;
        end else begin
            wr_r  <= wr_r + AW'(do_push);
            rd_r  <= rd_r + AW'(do_pop);
            cnt_r <= cnt_nxt;
            if (cnt_nxt > wm_r) begin
                wm_r <= cnt_nxt;
            end
        end
    end

    occ_bound_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) cnt_r <= (AW+1)'(DEPTH))
        else $error("Event queue occupancy above its depth.");
    wmark_covers_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i) wm_r >= cnt_r)
        else $error("Watermark below current occupancy.");
    fifo_head_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (do_push && q.empty) |=> (q.rdata == $past(q.wdata)))
        else $error("Head of empty queue is not the first pushed entry.");
endmodule

// ### tb/dcq_te_model.sv
// Model of the two transfer engines: stalls on command and logs requests.
module dcq_te_model (
    input  wire logic        clk_sys_i,
    input  wire logic        hold_i,
    input  wire logic [1:0]  vld_i,
    input  wire logic [31:0] src_i,
    output logic      [1:0]  rdy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] got_src [8];
    logic [1:0]  got_eng [8];
    int          n_got = 0;
    // Both engines stay busy while held, so events pile up in the queues.
    assign rdy_o = hold_i ? 2'b00 : 2'b11;
    // A request stands one cycle only, so it is logged at that edge.
    always @(posedge clk_sys_i) begin
        if (vld_i != 2'b00 && n_got < 8) begin
            got_src[n_got] <= src_i;
            got_eng[n_got] <= vld_i;
            n_got <= n_got + 1;
        end
    end
endmodule

// ### tb/tb_top.sv
// Testbench for the DMA channel controller.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcq_pkg::*;
    logic                   clk_sys_i = 1'b0;
    logic                   rst_n_i   = 1'b0;
    logic [N_DMA-1:0]       sw_evt    = '0;
    logic                   wr        = 1'b0;
    logic [SET_W-1:0]       wr_set_n  = '0;
    logic [WORD_W-1:0]      wr_word   = '0;
    logic [31:0]            wr_data   = '0;
    logic [N_QCH*SET_W-1:0] qmap;
    logic [N_DMA-1:0]       dsel      = '0;
    logic                   clr       = 1'b0;
    logic                   hold      = 1'b1;
    logic [1:0]             rdy;
    logic [1:0]             vld;
    logic [31:0]            src;
    logic [N_DMA-1:0]       missed;
    logic                   nerr;
    logic                   eirq;
    logic [9:0]             occ;
    logic [N_DMA-1:0]       pev       = '0;
    logic                   dirq;
    logic [5:0]             dcode;
    logic [5:0]             code_seen = '0;
    logic [1:0]             ovf;
    logic [9:0]             wm;
    int                     n_done    = 0;
    int                     n_mismatch = 0;
    int                     compares   = 0;
    // The clock toggles every 2 ns, half of its 4 ns period.
    always #2 clk_sys_i = ~clk_sys_i;
    dcq_te_model part_u (.clk_sys_i(clk_sys_i), .hold_i(hold), .vld_i(vld), .src_i(src), .rdy_o(rdy));
    dcq_channel_ctrl dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .dma_evt_i(pev), .sw_evt_set_i(sw_evt),
        .ctx_wr_i(wr), .ctx_wr_set_i(wr_set_n), .ctx_wr_word_i(wr_word), .ctx_wr_data_i(wr_data),
        .qch_map_i(qmap), .dma_que_sel_i(dsel), .qch_que_sel_i(8'h00), .err_clr_i(clr), .te_ready_i(rdy),
        .te_req_valid_o(vld), .te_req_opt_o(), .te_req_src_o(src), .te_req_dst_o(), .te_req_cnt_o(),
        .te_req_bidx_o(), .te_req_cidx_o(), .te_req_ccnt_o(), .done_irq_o(dirq), .done_code_o(dcode),
        .err_irq_o(eirq), .dma_missed_o(missed), .qch_missed_o(), .null_err_o(nerr), .que_ovf_o(ovf),
        .que_occ_o(occ), .que_wmark_o(wm));
    // The completion pulse stands one cycle and the code moves on with the next request, so both are caught here.
    always @(posedge clk_sys_i) begin
        if (dirq === 1'b1) begin
            n_done    <= n_done + 1;
            code_seen <= dcode;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Writes one whole set, word 7 last; that write also fires the given events.
    task automatic put_set(input logic [6:0] s, input logic [31:0] a, input logic [63:0] e, input logic z);
        for (int w = 0; w < N_WORD; w++) begin
            @(negedge clk_sys_i);
            wr = 1'b1;
            wr_set_n = s;
            wr_word = 3'(w);
            wr_data = z ? 32'h0000_0000 : (w == 1) ? a : (w == 5) ? 32'h0000_FFFF :
                      (w == 2 || w == 7) ? 32'h0001_0001 : 32'h0000_0000;
            sw_evt = (w == 7) ? e : '0;
        end
        @(negedge clk_sys_i);
        wr = 1'b0;
        sw_evt = '0;
    endtask
    // Writes one word with the given events in the same cycle.
    task automatic put_word(input logic [6:0] s, input logic [2:0] n, input logic [31:0] d, input logic [63:0] e);
        @(negedge clk_sys_i);
        wr = 1'b1;
        wr_set_n = s;
        wr_word = n;
        wr_data = d;
        sw_evt = e;
        @(negedge clk_sys_i);
        wr = 1'b0;
        sw_evt = '0;
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 100 && part_u.n_got < n; i++) @(negedge clk_sys_i);
        if (part_u.n_got < n) begin
            n_mismatch++;
            $display("unexpected at %0t: request wait ran out", $time);
            tally_and_finish();
        end
    endtask
    // Regular 3 and 5 fire with quick 0 in one cycle while both engines stall.
    task automatic sc_order;
        dsel[5] = 1'b1;
        put_set(7'd3, 32'h3000, '0, 1'b0);
        put_set(7'd5, 32'h5000, '0, 1'b0);
        put_set(7'd120, 32'hA000, 64'h28, 1'b0);
        repeat (4) @(negedge clk_sys_i);
        check(32'(occ), 32'h22);
        hold = 1'b0;
        wait_got(3);
        check(part_u.got_src[0], 32'h3000);
        check(part_u.got_src[1], 32'hA000);
        check(part_u.got_src[2], 32'h5000);
        check(32'({part_u.got_eng[0], part_u.got_eng[1], part_u.got_eng[2]}), 32'h16);
    endtask
    // A peripheral event repeats on channel 5 while channel 3 wins the push; it is flagged, then cleared.
    task automatic sc_missed;
        hold = 1'b1;
        @(negedge clk_sys_i);
        sw_evt[3] = 1'b1;
        pev[5] = 1'b1;
        @(negedge clk_sys_i);
        sw_evt[3] = 1'b0;
        @(negedge clk_sys_i);
        pev[5] = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check(32'({missed[5], eirq}), 32'h3);
        clr = 1'b1;
        @(negedge clk_sys_i);
        clr = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check(32'({missed[5], eirq}), 32'h0);
        hold = 1'b0;
        wait_got(5);
        check(part_u.got_src[3], 32'h3000);
        check(part_u.got_src[4], 32'h5000);
    endtask
    // An all-zero set raises the null flag and submits nothing.
    task automatic sc_null;
        put_set(7'd2, 32'h0, 64'h4, 1'b1);
        repeat (10) @(negedge clk_sys_i);
        check(32'({nerr, eirq}), 32'h3);
        check(32'(part_u.n_got), 32'h5);
    endtask
    // Set 10 ends with a completion, chains channel 11 and reloads itself from set 12.
    task automatic sc_link;
        put_set(7'd11, 32'hB000, '0, 1'b0);
        put_set(7'd12, 32'hC000, '0, 1'b0);
        put_set(7'd10, 32'h1000, '0, 1'b0);
        put_word(7'd10, W_LINK, 32'h0000_0180, '0);
        put_word(7'd10, W_OPT, 32'h0050_B000, 64'h400);
        wait_got(7);
        check(part_u.got_src[5], 32'h1000);
        check(part_u.got_src[6], 32'hB000);
        check(32'(code_seen), 32'hB);
        check(32'(n_done), 32'h1);
        put_word(7'd12, W_BIDX, 32'h0000_0000, 64'h400);
        wait_got(8);
        check(part_u.got_src[7], 32'hC000);
    endtask
    // A held peripheral event on channel 3 fills the first queue while both engines stall.
    task automatic sc_ovf;
        hold = 1'b1;
        pev[3] = 1'b1;
        repeat (20) @(negedge clk_sys_i);
        pev[3] = 1'b0;
        check(32'(occ), 32'h10);
        check(32'(ovf), 32'h1);
        check(32'(wm), 32'h30);
    endtask
    initial begin
        for (int k = 0; k < N_QCH; k++) qmap[k*SET_W +: SET_W] = 7'(120 + k);
        repeat (10) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        check(32'({occ, vld}), 32'h0);
        sc_order();
        sc_missed();
        sc_null();
        sc_link();
        sc_ovf();
        tally_and_finish();
    end
endmodule
